// [verilog/measurement_status_flags.sv]
// Purpose: Condition and event status words for margin, overload, timing, transducer
// Assumes: Inputs synchronous to ref_clk; one query per cycle at most
// Notes: Answer appears one cycle after the query
// Function
// - Margin status bit n-1 is set while limit margin n (1..8) is violated.
// - Bit 15 of every word in the bank always reads zero.
// - Overload bit 0 is set on an RF overload that distorts without damage.
// - Overload bit 2 is set on an overload in the IF path.
// - Overload bit 3 is set when the RF input level exceeds the maximum.
// - An input overload disconnects the RF input from the mixer until reconnect is requested.
// - Timing bit 1 is set while the sweep time is too short.
// - Transducer bit n-1 is set when subrange n (1..10) is reached.
// - Transducer bits 10 and 11 show assignment to RF input 1 and 2.
// - Transducer bit 14 is set while at a subrange changeover point.
// - A transducer break is flagged with the next range until continue is commanded.
// - Overload, timing and transducer words exist once per channel.
// - Each query returns either the condition part or the event part.
// - Margin words exist once per channel and window pair.
`timescale 1ns/1ps
module measurement_status_flags (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Measurement conditions
  input wire status_flags_pkg::chan_cond_t [status_flags_pkg::NUM_CHAN-1:0] chan_cond,
  input wire logic [status_flags_pkg::NUM_MARGIN_REGS-1:0][status_flags_pkg::MARGIN_CNT-1:0]
    margin_fail,
  // Status queries
  input wire logic qry_valid,
  input wire status_flags_pkg::query_t qry,
  output logic ans_valid,
  output logic [status_flags_pkg::WORD_W-1:0] ans_data,
  // Sweep control
  input wire logic continue_measurement_cmd,
  input wire logic [status_flags_pkg::CHAN_W-1:0] continue_chan,
  input wire logic reconnect_req,
  input wire logic [status_flags_pkg::CHAN_W-1:0] reconnect_chan,
  output logic [status_flags_pkg::NUM_CHAN-1:0] rf_disconnect,
  output logic [status_flags_pkg::NUM_CHAN-1:0] sweep_paused,
  output logic [status_flags_pkg::NUM_CHAN-1:0][status_flags_pkg::RANGE_W-1:0] next_range
);

  function automatic logic [status_flags_pkg::IDX_W-1:0] reg_index(
    input status_flags_pkg::query_t q
  );
    int idx;
    idx = 0;
    unique case (q.sel)
      status_flags_pkg::SEL_MARGIN: begin
        idx = status_flags_pkg::BASE_MARGIN + int'(q.chan) * status_flags_pkg::NUM_WIN
          + int'(q.win);
      end
      status_flags_pkg::SEL_OVERLOAD: begin
        idx = status_flags_pkg::BASE_OVERLOAD + int'(q.chan);
      end
      status_flags_pkg::SEL_TIMING: begin
        idx = status_flags_pkg::BASE_TIMING + int'(q.chan);
      end
      status_flags_pkg::SEL_SUBRANGE: begin
        idx = status_flags_pkg::BASE_SUBRANGE + int'(q.chan);
      end
    endcase
    return idx[status_flags_pkg::IDX_W-1:0];
  endfunction : reg_index

  // One past the highest subrange reached, 1-based, capped at 10
  function automatic logic [status_flags_pkg::RANGE_W-1:0] range_after(
    input logic [status_flags_pkg::SUBRANGE_CNT-1:0] reached
  );
    int nxt;
    nxt = 1;
    for (int i = 0; i < status_flags_pkg::SUBRANGE_CNT; i++) begin
      if (reached[i]) begin
        nxt = i + 2;
      end
    end
    if (nxt > status_flags_pkg::SUBRANGE_CNT) begin
      nxt = status_flags_pkg::SUBRANGE_CNT;
    end
    return nxt[status_flags_pkg::RANGE_W-1:0];
  endfunction : range_after

  logic [status_flags_pkg::NUM_REGS-1:0][status_flags_pkg::WORD_W-1:0] cond_word;
  logic [status_flags_pkg::NUM_REGS-1:0][status_flags_pkg::WORD_W-1:0] cond_ff;
  logic [status_flags_pkg::NUM_REGS-1:0][status_flags_pkg::WORD_W-1:0] nxt_cond;
  logic [status_flags_pkg::NUM_REGS-1:0][status_flags_pkg::WORD_W-1:0] evt_ff;
  logic [status_flags_pkg::NUM_REGS-1:0][status_flags_pkg::WORD_W-1:0] nxt_evt;
  logic ans_valid_ff;
  logic nxt_ans_valid;
  logic [status_flags_pkg::WORD_W-1:0] ans_data_ff;
  logic [status_flags_pkg::WORD_W-1:0] nxt_ans_data;
  logic [status_flags_pkg::IDX_W-1:0] qry_idx;
  logic [status_flags_pkg::NUM_CHAN-1:0] disc_ff;
  logic [status_flags_pkg::NUM_CHAN-1:0] nxt_disc;
  logic [status_flags_pkg::NUM_CHAN-1:0] pause_ff;
  logic [status_flags_pkg::NUM_CHAN-1:0] nxt_pause;
  logic [status_flags_pkg::NUM_CHAN-1:0] edge_seen_ff;
  logic [status_flags_pkg::NUM_CHAN-1:0] nxt_edge_seen;
  logic [status_flags_pkg::NUM_CHAN-1:0][status_flags_pkg::RANGE_W-1:0] range_ff;
  logic [status_flags_pkg::NUM_CHAN-1:0][status_flags_pkg::RANGE_W-1:0] nxt_range;

  assign qry_idx = reg_index(qry);

  // Live condition words, built up from WORD_RST so unused bits and bit 15 stay zero
  genvar g;
  generate
    for (g = 0; g < status_flags_pkg::NUM_MARGIN_REGS; g++) begin : g_margin
      always_comb begin
        cond_word[status_flags_pkg::BASE_MARGIN + g] = status_flags_pkg::WORD_RST;
        cond_word[status_flags_pkg::BASE_MARGIN + g][status_flags_pkg::MARGIN_LSB +:
          status_flags_pkg::MARGIN_CNT] = margin_fail[g];
      end
    end
    for (g = 0; g < status_flags_pkg::NUM_CHAN; g++) begin : g_chan
      always_comb begin
        cond_word[status_flags_pkg::BASE_OVERLOAD + g] = status_flags_pkg::WORD_RST;
        cond_word[status_flags_pkg::BASE_OVERLOAD + g][status_flags_pkg::OVL_RF_BIT] =
          chan_cond[g].rf_overload;
        cond_word[status_flags_pkg::BASE_OVERLOAD + g][status_flags_pkg::OVL_IF_BIT] =
          chan_cond[g].if_overload;
        cond_word[status_flags_pkg::BASE_OVERLOAD + g][status_flags_pkg::OVL_INPUT_BIT] =
          chan_cond[g].input_overload;
        cond_word[status_flags_pkg::BASE_TIMING + g] = status_flags_pkg::WORD_RST;
        cond_word[status_flags_pkg::BASE_TIMING + g][status_flags_pkg::TIM_SHORT_BIT] =
          chan_cond[g].sweep_too_short;
        cond_word[status_flags_pkg::BASE_SUBRANGE + g] = status_flags_pkg::WORD_RST;
        cond_word[status_flags_pkg::BASE_SUBRANGE + g][status_flags_pkg::TRD_RANGE_LSB +:
          status_flags_pkg::SUBRANGE_CNT] = chan_cond[g].subrange;
        cond_word[status_flags_pkg::BASE_SUBRANGE + g][status_flags_pkg::TRD_IN1_BIT] =
          chan_cond[g].on_input1;
        cond_word[status_flags_pkg::BASE_SUBRANGE + g][status_flags_pkg::TRD_IN2_BIT] =
          chan_cond[g].on_input2;
        cond_word[status_flags_pkg::BASE_SUBRANGE + g][status_flags_pkg::TRD_EDGE_BIT] =
          chan_cond[g].at_changeover;
      end
    end
  endgenerate

  // Condition, event and answer
  always_comb begin
    nxt_ans_valid = qry_valid;
    nxt_ans_data = ans_data_ff;
    for (int r = 0; r < status_flags_pkg::NUM_REGS; r++) begin
      nxt_cond[r] = cond_word[r];
      nxt_evt[r] = evt_ff[r];
      // Read clears, but a fresh rising edge in the same cycle survives
      if (qry_valid && qry.part == status_flags_pkg::PART_EVENT &&
          qry_idx == r[status_flags_pkg::IDX_W-1:0]) begin
        nxt_evt[r] = status_flags_pkg::WORD_RST;
      end
      nxt_evt[r] = nxt_evt[r] | (cond_word[r] & ~cond_ff[r]);
      nxt_evt[r][status_flags_pkg::TOP_BIT] = 1'b0;
    end
    if (qry_valid) begin
      if (qry.part == status_flags_pkg::PART_EVENT) begin
        nxt_ans_data = evt_ff[qry_idx];
      end else begin
        nxt_ans_data = cond_ff[qry_idx];
      end
      nxt_ans_data[status_flags_pkg::TOP_BIT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int r = 0; r < status_flags_pkg::NUM_REGS; r++) begin
        cond_ff[r] <= status_flags_pkg::WORD_RST;
        evt_ff[r] <= status_flags_pkg::WORD_RST;
      end
      ans_valid_ff <= 1'b0;
      ans_data_ff <= status_flags_pkg::WORD_RST;
    end else begin
      cond_ff <= nxt_cond;
      evt_ff <= nxt_evt;
      ans_valid_ff <= nxt_ans_valid;
      ans_data_ff <= nxt_ans_data;
    end
  end

  // Input protection and transducer break handshake
  always_comb begin
    nxt_disc = disc_ff;
    nxt_pause = pause_ff;
    nxt_range = range_ff;
    nxt_edge_seen = edge_seen_ff;
    for (int c = 0; c < status_flags_pkg::NUM_CHAN; c++) begin
      nxt_edge_seen[c] = chan_cond[c].at_changeover;
      if (reconnect_req && reconnect_chan == c[status_flags_pkg::CHAN_W-1:0]) begin
        nxt_disc[c] = 1'b0;
      end
      // Overload still present keeps the input cut even against a reconnect
      if (chan_cond[c].input_overload) begin
        nxt_disc[c] = 1'b1;
      end
      if (continue_measurement_cmd && continue_chan == c[status_flags_pkg::CHAN_W-1:0]) begin
        nxt_pause[c] = 1'b0;
      end
      if (chan_cond[c].at_changeover && !edge_seen_ff[c]) begin
        nxt_pause[c] = 1'b1;
        nxt_range[c] = range_after(chan_cond[c].subrange);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      disc_ff <= '0;
      pause_ff <= '0;
      edge_seen_ff <= '0;
      for (int c = 0; c < status_flags_pkg::NUM_CHAN; c++) begin
        range_ff[c] <= status_flags_pkg::RANGE_RST;
      end
    end else begin
      disc_ff <= nxt_disc;
      pause_ff <= nxt_pause;
      edge_seen_ff <= nxt_edge_seen;
      range_ff <= nxt_range;
    end
  end

  assign ans_valid = ans_valid_ff;
  assign ans_data = ans_data_ff;
  assign rf_disconnect = disc_ff;
  assign sweep_paused = pause_ff;
  assign next_range = range_ff;

endmodule : measurement_status_flags

// [verilog/status_flags_pkg.sv]
// Purpose: Shared constants and types for the measurement status flag bank
// Assumes: One instrument clock, synchronous reset
// Notes: Channel and window counts are fixed build constants
package status_flags_pkg;
  localparam int NUM_CHAN = 2;
  localparam int NUM_WIN = 2;
  localparam int CHAN_W = 1;
  localparam int WIN_W = 1;
  localparam int WORD_W = 16;
  localparam int MARGIN_CNT = 8;
  localparam int SUBRANGE_CNT = 10;
  localparam int RANGE_W = 4;
  localparam int NUM_MARGIN_REGS = NUM_CHAN * NUM_WIN;
  localparam int NUM_REGS = NUM_MARGIN_REGS + 3 * NUM_CHAN;
  localparam int IDX_W = 4;

  // Base index of each register family in the flat register array
  localparam int BASE_MARGIN = 0;
  localparam int BASE_OVERLOAD = NUM_MARGIN_REGS;
  localparam int BASE_TIMING = NUM_MARGIN_REGS + NUM_CHAN;
  localparam int BASE_SUBRANGE = NUM_MARGIN_REGS + 2 * NUM_CHAN;

  // Bit positions
  localparam int MARGIN_LSB = 0;
  localparam int OVL_RF_BIT = 0;
  localparam int OVL_IF_BIT = 2;
  localparam int OVL_INPUT_BIT = 3;
  localparam int TIM_SHORT_BIT = 1;
  localparam int TRD_RANGE_LSB = 0;
  localparam int TRD_IN1_BIT = 10;
  localparam int TRD_IN2_BIT = 11;
  localparam int TRD_EDGE_BIT = 14;
  localparam int TOP_BIT = 15;

  // Bits that may ever read as one, then reset values
  localparam logic [WORD_W-1:0] MARGIN_MASK = 16'h00FF;
  localparam logic [WORD_W-1:0] OVL_MASK = 16'h000D;
  localparam logic [WORD_W-1:0] TIM_MASK = 16'h0002;
  localparam logic [WORD_W-1:0] TRD_MASK = 16'h4FFF;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [RANGE_W-1:0] RANGE_RST = 4'h0;

  typedef enum logic [1:0] {
    SEL_MARGIN = 2'b00,
    SEL_OVERLOAD = 2'b01,
    SEL_TIMING = 2'b10,
    SEL_SUBRANGE = 2'b11
  } reg_sel_t;

  typedef enum logic {
    PART_COND = 1'b0,
    PART_EVENT = 1'b1
  } reg_part_t;

  typedef struct packed {
    logic [SUBRANGE_CNT-1:0] subrange;
    logic on_input1;
    logic on_input2;
    logic at_changeover;
    logic rf_overload;
    logic if_overload;
    logic input_overload;
    logic sweep_too_short;
  } chan_cond_t;

  typedef struct packed {
    reg_sel_t sel;
    reg_part_t part;
    logic [CHAN_W-1:0] chan;
    logic [WIN_W-1:0] win;
  } query_t;
endpackage : status_flags_pkg

// [tb/measurement_status_flags_sva.sv]
// Purpose: Port checker for the status flag bank
// Assumes: One clock, rst synchronous active high
// Notes: Protection and break paths are watched on channel 0 only
`timescale 1ns/1ps
module measurement_status_flags_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Conditions and queries
  input wire status_flags_pkg::chan_cond_t [1:0] chan_cond,
  input wire logic qry_valid,
  input wire status_flags_pkg::query_t qry,
  input wire logic ans_valid,
  input wire logic [15:0] ans_data,
  // Sweep control
  input wire logic continue_measurement_cmd,
  input wire logic [0:0] continue_chan,
  input wire logic reconnect_req,
  input wire logic [0:0] reconnect_chan,
  input wire logic [1:0] rf_disconnect,
  input wire logic [1:0] sweep_paused,
  input wire logic [1:0][3:0] next_range
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_msb_zero: assert property (ans_data[15] == 1'b0)
    else $error("answer top bit set");
  a_answer_next: assert property (qry_valid |=> ans_valid)
    else $error("query not answered next cycle");
  a_answer_only: assert property (!qry_valid |=> !ans_valid)
    else $error("answer without query");
  a_ovl_unused: assert property (qry_valid && qry.sel == status_flags_pkg::SEL_OVERLOAD
    |=> (ans_data & ~status_flags_pkg::OVL_MASK) == 16'h0000)
    else $error("unused overload bit set");
  a_disc_set: assert property (chan_cond[0].input_overload |=> rf_disconnect[0])
    else $error("input not cut on overload");
  a_disc_hold: assert property (rf_disconnect[0] && !(reconnect_req && reconnect_chan == 1'h0)
    |=> rf_disconnect[0])
    else $error("input reconnected unasked");
  a_pause_set: assert property ($rose(chan_cond[0].at_changeover)
    |=> sweep_paused[0] && next_range[0] inside {[4'h1:4'hA]})
    else $error("break not flagged");
  a_pause_clear: assert property (sweep_paused[0] && continue_measurement_cmd &&
    continue_chan == 1'h0 && !$rose(chan_cond[0].at_changeover) |=> !sweep_paused[0])
    else $error("continue ignored");

  c_event_read: cover property (qry_valid && qry.part == status_flags_pkg::PART_EVENT);
  c_reconnect: cover property (rf_disconnect[0] && reconnect_req);
  c_resume: cover property (sweep_paused[0] && continue_measurement_cmd);
endmodule : measurement_status_flags_sva

bind measurement_status_flags measurement_status_flags_sva measurement_status_flags_sva_i (
  .ref_clk(ref_clk), .rst(rst), .chan_cond(chan_cond), .qry_valid(qry_valid), .qry(qry),
  .ans_valid(ans_valid), .ans_data(ans_data),
  .continue_measurement_cmd(continue_measurement_cmd), .continue_chan(continue_chan),
  .reconnect_req(reconnect_req), .reconnect_chan(reconnect_chan),
  .rf_disconnect(rf_disconnect), .sweep_paused(sweep_paused), .next_range(next_range));

// [tb/status_ctrl_model.sv]
// Purpose: Remote controller issuing status queries and sweep commands
// Assumes: Drives at the falling edge of ref_clk
// Notes: Released query fields are scrambled, not held
`timescale 1ns/1ps
module status_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Query bus
  output logic qry_valid,
  output status_flags_pkg::query_t qry,
  input wire logic ans_valid,
  input wire logic [15:0] ans_data,
  // Commands
  output logic continue_measurement_cmd,
  output logic [0:0] continue_chan,
  output logic reconnect_req,
  output logic [0:0] reconnect_chan
);
  initial begin
    qry_valid = 1'b0;
    qry = 5'h00;
    continue_measurement_cmd = 1'b0;
    continue_chan = 1'h0;
    reconnect_req = 1'b0;
    reconnect_chan = 1'h0;
  end
  // One word per query, answered one edge after it is taken
  task automatic ask(input logic [1:0] s, input logic p, input logic [1:0] cw,
      output logic [15:0] w);
    @(negedge ref_clk);
    qry_valid = 1'b1;
    qry = {s, p, cw};
    @(negedge ref_clk);
    // Answer valid stands one cycle only, so take it before the next edge
    w = ans_valid ? ans_data : 16'hXXXX;
    qry_valid = 1'b0;
    qry = ~qry;
  endtask : ask
  // Resume a paused sweep or reconnect the input
  task automatic cmd(input logic rec, input logic [0:0] c);
    @(negedge ref_clk);
    continue_measurement_cmd = !rec;
    continue_chan = c;
    reconnect_req = rec;
    reconnect_chan = c;
    @(negedge ref_clk);
    continue_measurement_cmd = 1'b0;
    reconnect_req = 1'b0;
  endtask : cmd
endmodule : status_ctrl_model

// [tb/tb_measurement_status_flags.sv]
// Purpose: Self-checking bench for the status flag bank
// Assumes: Conditions driven at the falling edge
// Notes: Expected words written as hex literals
`timescale 1ns/1ps
module tb_measurement_status_flags;
  logic ref_clk, rst, qry_valid, ans_valid, cont, rec;
  logic [0:0] cont_ch, rec_ch;
  status_flags_pkg::query_t qry;
  status_flags_pkg::chan_cond_t [1:0] cc;
  logic [3:0][7:0] mf;
  logic [15:0] ans_data, w;
  logic [1:0] disc, paused;
  logic [1:0][3:0] nr;
  int failures, n_checks;

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  measurement_status_flags measurement_status_flags_i (.ref_clk(ref_clk), .rst(rst),
    .chan_cond(cc), .margin_fail(mf), .qry_valid(qry_valid), .qry(qry),
    .ans_valid(ans_valid), .ans_data(ans_data), .continue_measurement_cmd(cont),
    .continue_chan(cont_ch), .reconnect_req(rec), .reconnect_chan(rec_ch),
    .rf_disconnect(disc), .sweep_paused(paused), .next_range(nr));
  status_ctrl_model status_ctrl_model_i (.ref_clk(ref_clk), .qry_valid(qry_valid), .qry(qry),
    .ans_valid(ans_valid), .ans_data(ans_data), .continue_measurement_cmd(cont),
    .continue_chan(cont_ch), .reconnect_req(rec), .reconnect_chan(rec_ch));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [1:0] s, input logic p, input logic [1:0] cw,
      input logic [15:0] e);
    status_ctrl_model_i.ask(s, p, cw, w);
    chk("answer", e, w);
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // About 70 cycles of tests, generous margin
  initial begin
    #500000;
    failures++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    cc = '0;
    mf = '0;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    for (int s = 0; s < 4; s++) rd(2'(s), 1'b0, 2'h1, 16'h0000);
    for (int i = 0; i < 4; i++) mf[i] = 8'hA5 ^ 8'(i);
    for (int i = 0; i < 4; i++) begin
      rd(2'h0, 1'b0, 2'(i), {8'h00, 8'hA5 ^ 8'(i)});
      rd(2'h0, 1'b1, 2'(i), {8'h00, 8'hA5 ^ 8'(i)});
      rd(2'h0, 1'b1, 2'(i), 16'h0000);
    end
    $display("test margin done");
    cc[0].rf_overload = 1'b1;
    cc[0].if_overload = 1'b1;
    cc[0].input_overload = 1'b1;
    rd(2'h1, 1'b0, 2'h0, 16'h000D);
    rd(2'h1, 1'b1, 2'h0, 16'h000D);
    rd(2'h1, 1'b0, 2'h2, 16'h0000);
    chk("disconnect", 16'h0001, {14'h0000, disc});
    cc[0].input_overload = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("disconnect", 16'h0001, {14'h0000, disc});
    status_ctrl_model_i.cmd(1'b1, 1'h0);
    chk("disconnect", 16'h0000, {14'h0000, disc});
    cc[1].sweep_too_short = 1'b1;
    rd(2'h2, 1'b0, 2'h2, 16'h0002);
    rd(2'h2, 1'b0, 2'h0, 16'h0000);
    $display("test overload done");
    cc[0].subrange = 10'h007;
    cc[0].on_input1 = 1'b1;
    cc[0].at_changeover = 1'b1;
    rd(2'h3, 1'b0, 2'h0, 16'h4407);
    chk("break", 16'h0041, {8'h00, nr[0], 2'h0, paused});
    status_ctrl_model_i.cmd(1'b0, 1'h0);
    chk("break", 16'h0000, {14'h0000, paused});
    cc[1].subrange = 10'h3FF;
    cc[1].on_input2 = 1'b1;
    rd(2'h3, 1'b0, 2'h2, 16'h0BFF);
    cc[0].at_changeover = 1'b0;
    cc[0].subrange = 10'h3FF;
    @(negedge ref_clk);
    cc[0].at_changeover = 1'b1;
    @(negedge ref_clk);
    chk("break", 16'h00A1, {8'h00, nr[0], 2'h0, paused});
    $display("test transducer done");
    wrap_up();
  end
endmodule : tb_measurement_status_flags
